// ==== inc/bm_pkg.sv ====
// Constants for the battery monitor paged memory block
package bm_pkg;
  // Timing
  localparam longint CLK_HZ = 200_000_000;
  localparam longint SEC_MS = 1000;
  localparam longint NV_COPY_MS = 2;
  localparam longint VCONV_MS = 10;
  localparam longint TCONV_MS = 10;
  localparam longint SAMPLE_CHZ = 3641;
  localparam logic [31:0] NV_COPY_CYC = 32'(NV_COPY_MS * CLK_HZ / SEC_MS);
  localparam logic [31:0] VCONV_CYC = 32'(VCONV_MS * CLK_HZ / SEC_MS);
  localparam logic [31:0] TCONV_CYC = 32'(TCONV_MS * CLK_HZ / SEC_MS);
  localparam logic [31:0] SEC_CYC = 32'(CLK_HZ);
  localparam logic [31:0] SAMPLE_CYC = 32'(CLK_HZ * 100 / SAMPLE_CHZ);
  // Layout
  localparam int PAGES = 8;
  localparam int PAGE_BYTES = 8;
  localparam logic [3:0] CRC_IDX = 4'h8;
  localparam logic [2:0] FIRST_NV_PAGE = 3'h3;
  localparam logic [2:0] ACC_PAGE = 3'h7;
  localparam logic [2:0] STATUS_CONFIGURATION_OFS = 3'h0;
  localparam logic [2:0] THRESH_OFS = 3'h7;
  localparam logic [2:0] RSVD_OFS = 3'h7;
  localparam logic [7:0] RSVD_VAL = 8'hff;
  localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
  // Status/configuration bits
  localparam int CFG_CUR_EN = 0;
  localparam int CFG_ACC_EN = 1;
  localparam int CFG_SHADOW = 2;
  localparam int CFG_VSEL = 3;
  localparam int CFG_TBUSY = 4;
  localparam int CFG_EEBUSY = 5;
  localparam int CFG_CBUSY = 6;
  localparam logic [7:0] CFG_RESET = 8'h0f;
  // Commands
  localparam logic [2:0] OP_WRITE_SP = 3'h0;
  localparam logic [2:0] OP_READ_SP = 3'h1;
  localparam logic [2:0] OP_COPY_SP = 3'h2;
  localparam logic [2:0] OP_RECALL = 3'h3;
  localparam logic [2:0] OP_CONV_T = 3'h4;
  localparam logic [2:0] OP_CONV_V = 3'h5;

  typedef enum logic [2:0] {
    CV_IDLE = 3'b001,
    CV_TEMP = 3'b010,
    CV_VOLT = 3'b100
  } bm_conv_t;
endpackage

// ==== hw/bm_mem.sv ====
// Paged memory, scratchpads and housekeeping of the battery monitor
// Summary of operation
// - 64 bytes as eight 8-byte pages
// - Write scratchpad, read back, copy to page
// - Pages 0-2 volatile, 3-7 nonvolatile
// - Ninth scratchpad byte is CRC
// - Page 0 bytes 1-6 read-only
// - Status/configuration byte writable and volatile
// - Current enable runs converter at 36.41 Hz
// - Accumulator enable keeps totals in page 7
// - Shadow bit copies total increments to EEPROM
// - Voltage select picks supply or auxiliary input
// - Temperature busy while conversion runs
// - EEPROM busy during scratchpad copy to pages 3-7
// - Converter busy during voltage conversion
// - Page 0 holds temperature, voltage, current, threshold
// - Page 0 scratchpad values govern operation
// - Page 1 holds seconds, accumulator, offset
// - Page 1 byte 7 reads all ones
// - Page 2 holds two timestamps
// - CRC polynomial x^8+x^5+x^4+1
// - Seconds counter 32-bit, ticks each second
// - Recall snapshots seconds counter
`timescale 1ns/10ps
module bm_mem import bm_pkg::*; #(
  parameter logic [31:0] NV_COPY_CYCLES = NV_COPY_CYC,
  parameter logic [31:0] VCONV_CYCLES = VCONV_CYC,
  parameter logic [31:0] TCONV_CYCLES = TCONV_CYC,
  parameter logic [31:0] SEC_CYCLES = SEC_CYC,
  parameter logic [31:0] SAMPLE_CYCLES = SAMPLE_CYC
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Memory function command from the bus front end
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_op_i,
  input wire logic [2:0] cmd_page_i,
  input wire logic [3:0] cmd_byte_i,
  input wire logic [7:0] cmd_data_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // Measurement side
  input wire logic [15:0] temp_result_i,
  input wire logic [15:0] volt_result_i,
  input wire logic [15:0] current_i,
  input wire logic accum_inc_i,
  input wire logic chg_inc_i,
  input wire logic dis_inc_i,
  output logic current_sample_o,
  output logic volt_input_sel_o
);
  logic [7:0] mem_ff [PAGES][PAGE_BYTES];
  logic [7:0] sp_ff [PAGES][PAGE_BYTES];
  logic [31:0] secs_ff;
  logic [31:0] sec_div_ff;
  logic [31:0] smp_div_ff;
  logic [31:0] nv_cnt_ff;
  logic [31:0] cv_cnt_ff;
  logic [7:0] accum_ff;
  logic [15:0] chg_ff;
  logic [15:0] dis_ff;
  logic [15:0] temp_ff;
  logic [15:0] volt_ff;
  logic [15:0] cur_ff;
  bm_conv_t cv_state_ff;
  logic [7:0] cfg;
  logic temp_busy;
  logic conv_busy;
  logic eeprom_busy;
  logic do_write;
  logic do_read;
  logic do_copy;
  logic do_recall;
  logic cv_done;

  // Live configuration comes from the page 0 scratchpad, not the stored copy
  assign cfg = sp_ff[0][STATUS_CONFIGURATION_OFS];
  assign temp_busy = (cv_state_ff == CV_TEMP);
  assign conv_busy = (cv_state_ff == CV_VOLT);
  assign eeprom_busy = (nv_cnt_ff != 32'h0);
  assign do_write = ce_i && cmd_valid_i && (cmd_op_i == OP_WRITE_SP);
  assign do_read = ce_i && cmd_valid_i && (cmd_op_i == OP_READ_SP);
  assign do_copy = ce_i && cmd_valid_i && (cmd_op_i == OP_COPY_SP) && !eeprom_busy;
  assign do_recall = ce_i && cmd_valid_i && (cmd_op_i == OP_RECALL);
  assign cv_done = (cv_state_ff != CV_IDLE) && (cv_cnt_ff == 32'h1);

  // Bitwise CRC, LSB first, reflected form of the polynomial
  function automatic logic [7:0] crc8(input logic [7:0] b [PAGE_BYTES]);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    fb = 1'b0;
    for (int i = 0; i < PAGE_BYTES; i++) begin
      for (int j = 0; j < 8; j++) begin
        fb = c[0] ^ b[i][j];
        c = {1'b0, c[7:1]};
        if (fb) begin
          c = c ^ CRC_POLY_REFL;
        end
      end
    end
    return c;
  endfunction

  function automatic logic wr_ok(input logic [2:0] pg, input logic [2:0] by);
    if (pg == 3'h0) begin
      return (by == STATUS_CONFIGURATION_OFS) || (by == THRESH_OFS);
    end
    if (pg == 3'h1) begin
      return by != RSVD_OFS;
    end
    return 1'b1;
  endfunction

  // Scratchpad: master writes and recalls from memory
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int p = 0; p < PAGES; p++) begin
        for (int b = 0; b < PAGE_BYTES; b++) begin
          sp_ff[p][b] <= 8'h00;
        end
      end
      sp_ff[0][STATUS_CONFIGURATION_OFS] <= CFG_RESET;
      sp_ff[1][RSVD_OFS] <= RSVD_VAL;
    end else if (do_write && cmd_byte_i < CRC_IDX && wr_ok(cmd_page_i, cmd_byte_i[2:0])) begin
      sp_ff[cmd_page_i][cmd_byte_i[2:0]] <= cmd_data_i;
    end else if (do_recall) begin
      for (int b = 0; b < PAGE_BYTES; b++) begin
        sp_ff[cmd_page_i][b] <= mem_ff[cmd_page_i][b];
      end
      if (cmd_page_i == 3'h0) begin
        sp_ff[0][1] <= temp_ff[7:0];
        sp_ff[0][2] <= temp_ff[15:8];
        sp_ff[0][3] <= volt_ff[7:0];
        sp_ff[0][4] <= volt_ff[15:8];
        sp_ff[0][5] <= cur_ff[7:0];
        sp_ff[0][6] <= cur_ff[15:8];
        // Config already in scratchpad stays live
        sp_ff[0][STATUS_CONFIGURATION_OFS] <= sp_ff[0][STATUS_CONFIGURATION_OFS];
        sp_ff[0][THRESH_OFS] <= sp_ff[0][THRESH_OFS];
      end else if (cmd_page_i == 3'h1) begin
        // Snapshot so a slow read sees one consistent time
        for (int b = 0; b < 4; b++) begin
          sp_ff[1][b] <= secs_ff[8*b +: 8];
        end
        sp_ff[1][4] <= accum_ff;
        sp_ff[1][RSVD_OFS] <= RSVD_VAL;
      end else if (cmd_page_i == ACC_PAGE && cfg[CFG_ACC_EN]) begin
        sp_ff[7][4] <= chg_ff[7:0];
        sp_ff[7][5] <= chg_ff[15:8];
        sp_ff[7][6] <= dis_ff[7:0];
        sp_ff[7][7] <= dis_ff[15:8];
      end
    end
  end

  // Page storage; pages 3-7 stand for the EEPROM array
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int p = 0; p < PAGES; p++) begin
        for (int b = 0; b < PAGE_BYTES; b++) begin
          mem_ff[p][b] <= 8'h00;
        end
      end
      mem_ff[0][STATUS_CONFIGURATION_OFS] <= CFG_RESET;
    end else if (do_copy) begin
      for (int b = 0; b < PAGE_BYTES; b++) begin
        if (wr_ok(cmd_page_i, 3'(b))) begin
          mem_ff[cmd_page_i][b] <= sp_ff[cmd_page_i][b];
        end
      end
    end else if (ce_i && cfg[CFG_ACC_EN] && cfg[CFG_SHADOW]) begin
      // Shadow keeps totals across power loss; master must not copy page 7 then
      mem_ff[ACC_PAGE][4] <= chg_ff[7:0];
      mem_ff[ACC_PAGE][5] <= chg_ff[15:8];
      mem_ff[ACC_PAGE][6] <= dis_ff[7:0];
      mem_ff[ACC_PAGE][7] <= dis_ff[15:8];
    end
  end

  // Nonvolatile copy busy time
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      nv_cnt_ff <= 32'h0;
    end else if (ce_i) begin
      if (do_copy && cmd_page_i >= FIRST_NV_PAGE) begin
        nv_cnt_ff <= NV_COPY_CYCLES;
      end else if (eeprom_busy) begin
        nv_cnt_ff <= nv_cnt_ff - 32'h1;
      end
    end
  end

  // One converter, temperature or voltage at a time
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cv_state_ff <= CV_IDLE;
      cv_cnt_ff <= 32'h0;
      temp_ff <= 16'h0;
      volt_ff <= 16'h0;
    end else if (ce_i) begin
      case (cv_state_ff)
        CV_IDLE: begin
          if (cmd_valid_i && cmd_op_i == OP_CONV_T) begin
            cv_state_ff <= CV_TEMP;
            cv_cnt_ff <= TCONV_CYCLES;
          end else if (cmd_valid_i && cmd_op_i == OP_CONV_V) begin
            cv_state_ff <= CV_VOLT;
            cv_cnt_ff <= VCONV_CYCLES;
          end
        end
        CV_TEMP: begin
          cv_cnt_ff <= cv_cnt_ff - 32'h1;
          if (cv_done) begin
            temp_ff <= temp_result_i;
            cv_state_ff <= CV_IDLE;
          end
        end
        CV_VOLT: begin
          cv_cnt_ff <= cv_cnt_ff - 32'h1;
          if (cv_done) begin
            volt_ff <= volt_result_i;
            cv_state_ff <= CV_IDLE;
          end
        end
        default: begin
          cv_state_ff <= CV_IDLE;
        end
      endcase
    end
  end

  // Elapsed seconds; a copy of page 1 presets it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      secs_ff <= 32'h0;
      sec_div_ff <= 32'h0;
    end else if (ce_i) begin
      sec_div_ff <= (sec_div_ff == SEC_CYCLES - 32'h1) ? 32'h0 : sec_div_ff + 32'h1;
      if (do_copy && cmd_page_i == 3'h1) begin
        secs_ff <= {sp_ff[1][3], sp_ff[1][2], sp_ff[1][1], sp_ff[1][0]};
      end else if (sec_div_ff == SEC_CYCLES - 32'h1) begin
        secs_ff <= secs_ff + 32'h1;
      end
    end
  end

  // Current sampling and integrated accumulator
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      smp_div_ff <= 32'h0;
      current_sample_o <= 1'b0;
      cur_ff <= 16'h0;
      accum_ff <= 8'h0;
    end else if (ce_i) begin
      current_sample_o <= 1'b0;
      if (!cfg[CFG_CUR_EN]) begin
        smp_div_ff <= 32'h0;
      end else if (smp_div_ff == SAMPLE_CYCLES - 32'h1) begin
        smp_div_ff <= 32'h0;
        current_sample_o <= 1'b1;
        cur_ff <= current_i;
      end else begin
        smp_div_ff <= smp_div_ff + 32'h1;
      end
      if (do_copy && cmd_page_i == 3'h1) begin
        accum_ff <= sp_ff[1][4];
      end else if (cfg[CFG_CUR_EN] && accum_inc_i) begin
        accum_ff <= accum_ff + 8'h1;
      end
    end
  end

  // Charge and discharge totals
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      chg_ff <= 16'h0;
      dis_ff <= 16'h0;
    end else if (ce_i && cfg[CFG_ACC_EN]) begin
      if (do_copy && cmd_page_i == ACC_PAGE) begin
        chg_ff <= {sp_ff[7][5], sp_ff[7][4]};
        dis_ff <= {sp_ff[7][7], sp_ff[7][6]};
      end else begin
        chg_ff <= chg_ff + {15'h0, chg_inc_i};
        dis_ff <= dis_ff + {15'h0, dis_inc_i};
      end
    end
  end

  // Read port; status byte shows live busy flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
      volt_input_sel_o <= 1'b1;
    end else if (ce_i) begin
      volt_input_sel_o <= cfg[CFG_VSEL];
      rd_valid_o <= do_read;
      if (do_read) begin
        if (cmd_byte_i >= CRC_IDX) begin
          rd_data_o <= crc8(sp_ff[cmd_page_i]);
        end else if (cmd_page_i == 3'h0 && cmd_byte_i[2:0] == STATUS_CONFIGURATION_OFS) begin
          rd_data_o <= {1'b0, conv_busy, eeprom_busy, temp_busy, cfg[3:0]};
        end else begin
          rd_data_o <= sp_ff[cmd_page_i][cmd_byte_i[2:0]];
        end
      end
    end
  end
endmodule // bm_mem

// ==== testbench/bm_mem_sva.sv ====
// Port assertions for the battery monitor memory block
`timescale 1ns/10ps
module bm_mem_sva import bm_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Commands
  input wire logic ce_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_op_i,
  input wire logic [2:0] cmd_page_i,
  input wire logic [3:0] cmd_byte_i,
  input wire logic [7:0] cmd_data_i,
  // Answers
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic current_sample_o,
  input wire logic volt_input_sel_o
);
  logic tk;
  logic rd_tk;
  logic st_tk;
  assign tk = cmd_valid_i && ce_i;
  assign rd_tk = tk && cmd_op_i == OP_READ_SP;
  assign st_tk = rd_tk && cmd_page_i == 3'h0 && cmd_byte_i == 4'h0;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_read_answer: assert property (rd_tk |=> rd_valid_o)
    else $error("read unanswered");
  a_no_stray: assert property (!rd_tk |=> !rd_valid_o)
    else $error("stray read strobe");
  a_data_holds: assert property (!rd_tk |=> $stable(rd_data_o))
    else $error("read data moved");
  a_rsvd_ones: assert property (rd_tk && cmd_page_i == 3'h1
    && cmd_byte_i == 4'h7 |=> rd_data_o == RSVD_VAL) else $error("reserved byte");
  a_status_top: assert property (st_tk |=> !rd_data_o[7])
    else $error("status bit 7 set");
  a_vsel_follow: assert property (tk && cmd_op_i == OP_WRITE_SP && cmd_page_i == 3'h0
    && cmd_byte_i == 4'h0 |-> ##2 volt_input_sel_o == $past(cmd_data_i[CFG_VSEL], 2))
    else $error("input select stale");
  // A frozen clock enable holds the pulse, so only an enabled edge must clear it
  a_sample_pulse: assert property (current_sample_o && ce_i |=> !current_sample_o [*8])
    else $error("sample tick too wide");
  a_temp_busy: assert property (tk && cmd_op_i == OP_CONV_T ##2 st_tk
    |=> rd_data_o[CFG_TBUSY]) else $error("temp busy clear");
  a_volt_busy: assert property (tk && cmd_op_i == OP_CONV_V ##2 st_tk
    |=> rd_data_o[CFG_CBUSY]) else $error("converter busy clear");
  a_copy_busy: assert property (tk && cmd_op_i == OP_COPY_SP
    && cmd_page_i >= FIRST_NV_PAGE ##2 st_tk |=> rd_data_o[CFG_EEBUSY])
    else $error("eeprom busy clear");
endmodule // bm_mem_sva

bind bm_mem bm_mem_sva bm_mem_sva_inst (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
  .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_page_i(cmd_page_i),
  .cmd_byte_i(cmd_byte_i), .cmd_data_i(cmd_data_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .current_sample_o(current_sample_o),
  .volt_input_sel_o(volt_input_sel_o));

// ==== testbench/bm_meas_model.sv ====
// Measurement front end model feeding the battery monitor
`timescale 1ns/10ps
module bm_meas_model (
  // Clock and sample tick
  input wire logic clk_i,
  input wire logic sample_i,
  // Results and increment pulses
  output logic [15:0] temp_o,
  output logic [15:0] volt_o,
  output logic [15:0] cur_o,
  output logic accum_inc_o,
  output logic chg_inc_o,
  output logic dis_inc_o
);
  initial begin
    temp_o = 16'h1234;
    volt_o = 16'h0abc;
    cur_o = 16'h0100;
    {accum_inc_o, chg_inc_o, dis_inc_o} = 3'h0;
  end
  // New readings so a stale capture of a conversion shows
  task automatic set_meas(input logic [15:0] t, input logic [15:0] v);
    @(posedge clk_i);
    temp_o <= t;
    volt_o <= v;
  endtask
  // Fresh reading per tick, so a stale capture shows
  always @(posedge clk_i) if (sample_i) cur_o <= cur_o + 16'h0001;
  task automatic inc(input logic [2:0] sel);
    @(posedge clk_i);
    {accum_inc_o, chg_inc_o, dis_inc_o} <= sel;
    @(posedge clk_i);
    {accum_inc_o, chg_inc_o, dis_inc_o} <= 3'h0;
  endtask
endmodule // bm_meas_model

// ==== testbench/tb.sv ====
// Self-checking bench for the battery monitor memory block
`timescale 1ns/10ps
module tb;
  import bm_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cv = 1'b0;
  logic [2:0] op = 3'h0;
  logic [2:0] pg = 3'h0;
  logic [3:0] by = 4'h0;
  logic [7:0] dt = 8'h00;
  logic [7:0] rdat, crc, snap;
  logic rval, samp, vsel, acc_inc, chg, dis;
  logic [15:0] temp, volt, cur;
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  always #2.5 clk_i = ~clk_i;
  bm_mem #(.NV_COPY_CYCLES(32'h14), .VCONV_CYCLES(32'h1e), .TCONV_CYCLES(32'h19),
    .SEC_CYCLES(32'h32), .SAMPLE_CYCLES(32'h28)) bm_mem_inst (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .cmd_valid_i(cv), .cmd_op_i(op),
    .cmd_page_i(pg), .cmd_byte_i(by), .cmd_data_i(dt), .rd_data_o(rdat),
    .rd_valid_o(rval), .temp_result_i(temp), .volt_result_i(volt), .current_i(cur),
    .accum_inc_i(acc_inc), .chg_inc_i(chg), .dis_inc_i(dis), .current_sample_o(samp),
    .volt_input_sel_o(vsel));
  bm_meas_model bm_meas_model_inst (.clk_i(clk_i), .sample_i(samp), .temp_o(temp),
    .volt_o(volt), .cur_o(cur), .accum_inc_o(acc_inc), .chg_inc_o(chg), .dis_inc_o(dis));
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
    return c;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [2:0] o, input logic [2:0] p, input logic [3:0] b,
    input logic [7:0] d);
    @(posedge clk_i);
    {cv, op, pg, by, dt} <= {1'b1, o, p, b, d};
    @(posedge clk_i);
    cv <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] p, input logic [3:0] b);
    cmd(OP_READ_SP, p, b, 8'h00);
    // Strobe stands only in the cycle after the taking edge
    #1;
    chk({7'h00, rval}, 8'h01);
    @(posedge clk_i);
    #1;
    chk({7'h00, rval}, 8'h00);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // About twelve times the expected run
  initial begin
    repeat (8000) @(posedge clk_i);
    num_errors++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    chk({7'h00, vsel}, 8'h01);
    rd(3'h0, 4'h0);
    chk(rdat, CFG_RESET);
    cmd(OP_WRITE_SP, 3'h1, 4'h7, 8'h00);
    rd(3'h1, 4'h7);
    chk(rdat, RSVD_VAL);
    crc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      cmd(OP_WRITE_SP, 3'h2, 4'(i), 8'(i * 37 + 5));
      crc = crc8(crc, 8'(i * 37 + 5));
    end
    for (int i = 0; i < 9; i++) begin
      rd(3'h2, 4'(i));
      chk(rdat, (i == 8) ? crc : 8'(i * 37 + 5));
    end
    // Write taken while the enable is low must not land
    @(posedge clk_i);
    ce_i <= 1'b0;
    cmd(OP_WRITE_SP, 3'h2, 4'h0, 8'hee);
    ce_i <= 1'b1;
    rd(3'h2, 4'h0);
    chk(rdat, 8'h05);
    cmd(OP_COPY_SP, 3'h2, 4'h0, 8'h00);
    rd(3'h0, 4'h0);
    chk(rdat & 8'h20, 8'h00);
    cmd(OP_WRITE_SP, 3'h0, 4'h3, 8'h55);
    rd(3'h0, 4'h3);
    chk(rdat, 8'h00);
    cmd(OP_WRITE_SP, 3'h0, 4'h7, 8'h5a);
    rd(3'h0, 4'h7);
    chk(rdat, 8'h5a);
    cmd(OP_WRITE_SP, 3'h3, 4'h0, 8'h3c);
    cmd(OP_COPY_SP, 3'h3, 4'h0, 8'h00);
    rd(3'h0, 4'h0);
    chk(rdat & 8'h20, 8'h20);
    repeat (25) @(posedge clk_i);
    rd(3'h0, 4'h0);
    chk(rdat & 8'h20, 8'h00);
    cmd(OP_WRITE_SP, 3'h3, 4'h0, 8'h00);
    cmd(OP_RECALL, 3'h3, 4'h0, 8'h00);
    rd(3'h3, 4'h0);
    chk(rdat, 8'h3c);
    bm_meas_model_inst.set_meas(16'h2468, 16'h0d15);
    for (int k = 0; k < 2; k++) begin
      cmd(k ? OP_CONV_V : OP_CONV_T, 3'h0, 4'h0, 8'h00);
      rd(3'h0, 4'h0);
      chk(rdat & 8'h50, k ? 8'h40 : 8'h10);
      repeat (40) @(posedge clk_i);
      rd(3'h0, 4'h0);
      chk(rdat & 8'h50, 8'h00);
    end
    cmd(OP_RECALL, 3'h0, 4'h0, 8'h00);
    for (int i = 1; i < 5; i++) begin
      rd(3'h0, 4'(i));
      chk(rdat, 8'({volt, temp} >> (8 * (i - 1))));
    end
    // Page 7 gets no copy while totals are live; the shadow writes it
    repeat (3) bm_meas_model_inst.inc(3'h2);
    bm_meas_model_inst.inc(3'h5);
    cmd(OP_RECALL, 3'h7, 4'h0, 8'h00);
    rd(3'h7, 4'h4);
    chk(rdat, 8'h03);
    rd(3'h7, 4'h6);
    chk(rdat, 8'h01);
    cmd(OP_RECALL, 3'h1, 4'h0, 8'h00);
    rd(3'h1, 4'h4);
    chk(rdat, 8'h01);
    cmd(OP_WRITE_SP, 3'h1, 4'h0, 8'h10);
    cmd(OP_COPY_SP, 3'h1, 4'h0, 8'h00);
    repeat (120) @(posedge clk_i);
    cmd(OP_RECALL, 3'h1, 4'h0, 8'h00);
    rd(3'h1, 4'h0);
    snap = rdat;
    chk(8'(snap inside {8'h12, 8'h13}), 8'h01);
    repeat (60) @(posedge clk_i);
    rd(3'h1, 4'h0);
    chk(rdat, snap);
    @(posedge samp);
    #1;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (samp !== 1'b1);
    chk(8'(n), 8'h28);
    cmd(OP_WRITE_SP, 3'h0, 4'h0, 8'h06);
    repeat (3) @(posedge clk_i);
    chk({7'h00, vsel}, 8'h00);
    rd(3'h0, 4'h0);
    chk(rdat, 8'h06);
    n = 0;
    repeat (100) begin
      @(posedge clk_i);
      #1;
      n += int'(samp);
    end
    chk(8'(n), 8'h00);
    // Totals off: recall now shows only what the shadow kept
    cmd(OP_WRITE_SP, 3'h0, 4'h0, 8'h04);
    cmd(OP_RECALL, 3'h7, 4'h0, 8'h00);
    rd(3'h7, 4'h4);
    chk(rdat, 8'h03);
    final_report();
  end
endmodule // tb
